// file: rtl/fcs_pkg.sv
// What this block does
// [R1] 00FFh at command address: read array mode
// [R2] 0070h read status mode; 0050h clears status
// [R3] No read-status command in rewrite mode one
// [R4] Program is 0043h then four data writes
// [R5] Program 64 bits, four words, per set
// [R6] Upper 29 address bits fixed across data writes
// [R7] Data write low bits 000b,010b,100b,110b in order
// [R8] Each data write even address, 16-bit word
// [R9] Erase is 0020h then 00D0h in block
// [R10] Lock program 0077h+00D0h; 0071h lock status mode
// [R11] Protect program 0067h then confirm at bit address
// [R12] 0061h enters protect bit status mode
// [R13] Lock/protect status commands issued from RAM only
// [R14] Two protect bits per block, 0100h/0300h
// [R15] Any protect bit zero protects whole flash
// [R16] Bad command or confirm: reject, flag error
// [R17] Busy shown in status; commands ignored
package fcs_pkg;
  localparam logic [31:0] CMD_ADDR       = 32'hFFFFF800;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_READ_STAT  = 16'h0070;
  localparam logic [15:0] CMD_CLR_STAT   = 16'h0050;
  localparam logic [15:0] CMD_PROGRAM    = 16'h0043;
  localparam logic [15:0] CMD_ERASE      = 16'h0020;
  localparam logic [15:0] CMD_LOCK_PROG  = 16'h0077;
  localparam logic [15:0] CMD_LOCK_STAT  = 16'h0071;
  localparam logic [15:0] CMD_PROT_PROG  = 16'h0067;
  localparam logic [15:0] CMD_PROT_STAT  = 16'h0061;
  localparam logic [15:0] CMD_CONFIRM    = 16'h00D0;
  localparam logic [14:0] PROT0_OFS      = 15'h0100;
  localparam logic [14:0] PROT1_OFS      = 15'h0300;
  localparam int          PROT_SEL_BIT   = 9;
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  localparam int          PROG_WORDS     = 4;
  localparam logic [31:0] WORD_ALIGN     = 32'hFFFFFFF8;
  // Status register bits
  localparam int ST_READY    = 7;
  localparam int ST_ERASE_ER = 5;
  localparam int ST_PROG_ER  = 4;
  localparam logic [7:0] STAT_IDLE = 8'h80;  // Ready, no error flags
  // Register map of the surrounding flash control block
  localparam logic [31:0] FLASH_MODE_CONTROL    = 32'h00006;
  localparam logic [31:0] ERASE_BLOCK_COUNT_A   = 32'h0001C;
  localparam logic [31:0] ERASE_BLOCK_COUNT_B   = 32'h0010D;
  localparam logic [31:0] FLASH_CONTROL_ZERO    = 32'h40000;
  localparam logic [31:0] FLASH_STATUS_ZERO     = 32'h40001;
  localparam logic [31:0] FLASH_PROTECT_CONTROL = 32'h40008;
  localparam logic [31:0] FLASH_CONTROL_ONE     = 32'h40009;
  localparam logic [31:0] BLOCK_PROTECT_MODE_A  = 32'h4000A;
  localparam logic [31:0] BLOCK_PROTECT_MODE_B  = 32'h4000B;
  typedef enum logic [3:0] {
    OP_READ, OP_MODE_ARRAY, OP_MODE_STAT, OP_CLEAR, OP_PROGRAM,
    OP_ERASE, OP_LOCK_PROG, OP_MODE_LOCK, OP_PROT_PROG, OP_MODE_PROT
  } fcs_op_e;
endpackage

// file: rtl/fcs_if.sv
`timescale 1ns/1ps
`default_nettype none
// CPU-side access path into the flash sequencer
interface fcs_if;
  logic        req;    // Access request, held until ack
  logic        we;     // Write when high
  logic [31:0] addr;   // Byte address
  logic [15:0] wdata;  // Write word
  logic        ack;    // One-cycle answer
  logic [15:0] rdata;  // Read word, valid with ack
  modport dev  (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// file: rtl/fcs_device.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_device
  import fcs_pkg::*;
#(
  parameter int AW = 10,  // Word address bits of the array
  parameter int BW = 7    // Word address bits inside one block
) (
  input  wire logic clk,     // System clock
  input  wire logic arst_n,  // Async reset, active low
  fcs_if.dev        bus      // CPU access port
);
  localparam int NB  = 2 ** (AW - BW);
  localparam int POW = $bits(PROT0_OFS);  // Address bits that place a protect bit

  typedef enum logic [1:0] {MD_ARRAY, MD_STAT, MD_LOCK, MD_PROT} fcs_mode_e;
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_PDATA, SQ_ERASE_CF, SQ_LOCK_CF, SQ_PROT_CF, SQ_RUN_PROG, SQ_RUN_ERASE
  } fcs_seq_e;

  // State; the array and program buffer carry no reset, as flash has none
  logic [15:0] mem [2**AW];         // Flash array, not reset
  logic [15:0] pbuf [PROG_WORDS];   // Program data collected
  fcs_mode_e   mode_reg;
  fcs_seq_e    seq_reg;
  logic [7:0]  stat_reg;
  logic [NB-1:0] lock_reg;
  logic [NB-1:0] prot0_reg;
  logic [NB-1:0] prot1_reg;
  logic [1:0]  pcnt_reg;
  logic [BW-1:0] ecnt_reg;
  logic [AW-1:0] base_reg;
  logic        ack_reg;
  logic [15:0] rdata_reg;

  // Access decode
  wire         take     = bus.req && !ack_reg;
  wire         wr       = take && bus.we;
  wire         is_cmd   = bus.addr == CMD_ADDR;
  wire [AW-1:0] widx    = bus.addr[AW:1];
  wire [AW-BW-1:0] blk  = bus.addr[AW:BW+1];
  wire         busy     = seq_reg == SQ_RUN_PROG || seq_reg == SQ_RUN_ERASE;
  wire         all_prot = !(&prot0_reg) || !(&prot1_reg);      // [R15]
  wire         blk_bad  = all_prot || !lock_reg[blk];
  wire         confirm  = bus.wdata == CMD_CONFIRM;
  wire         at_prot0 = bus.addr[POW-1:0] == PROT0_OFS;       // [R14]
  wire         at_prot1 = bus.addr[POW-1:0] == PROT1_OFS;       // [R14]
  wire [2:0]   want_lo  = {pcnt_reg, 1'b0};
  // Data word must be even and at the next offset of the set
  wire         pd_ok    = !bus.addr[0]                          // [R8]
                          && bus.addr[2:0] == want_lo;          // [R7]
  wire [AW-1:0] pidx    = {base_reg[AW-1:2], pcnt_reg};
  wire [AW-1:0] eidx    = {base_reg[AW-1:BW], ecnt_reg};

  // Read answer by mode; status forced while busy
  wire [15:0] rd_word =
    (busy || mode_reg == MD_STAT) ? {8'h00, stat_reg} :           // [R2] [R17]
    mode_reg == MD_LOCK ? {15'h0000, lock_reg[blk]} :             // [R10]
    mode_reg == MD_PROT ? {15'h0000, bus.addr[PROT_SEL_BIT] ?     // [R12]
                           prot1_reg[blk] : prot0_reg[blk]} :
    mem[widx];                                                    // [R1]

  // Bus answer: one ack per request, the cycle after it is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg   <= take;
      rdata_reg <= take && !bus.we ? rd_word : rdata_reg;
    end
  end

  // Array writes: program words and erase sweep
  always_ff @(posedge clk) begin
    if (seq_reg == SQ_RUN_PROG)
      mem[pidx] <= pbuf[pcnt_reg];                                // [R5]
    else if (seq_reg == SQ_RUN_ERASE)
      mem[eidx] <= ERASED_WORD;                                   // [R9]
  end

  // Program data capture
  always_ff @(posedge clk) begin
    if (wr && seq_reg == SQ_PDATA)
      pbuf[pcnt_reg] <= bus.wdata;                                // [R4] [R8]
  end

  // Command sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg  <= MD_ARRAY;
      seq_reg   <= SQ_IDLE;
      stat_reg  <= STAT_IDLE;
      lock_reg  <= '1;
      prot0_reg <= '1;
      prot1_reg <= '1;
      pcnt_reg  <= 2'b00;
      ecnt_reg  <= '0;
      base_reg  <= '0;
    end else begin
      case (seq_reg)
        SQ_IDLE: begin
          // Mode commands act at once; two-word commands wait for a confirm
          if (wr && is_cmd) begin
            case (bus.wdata)
              CMD_READ_ARRAY: mode_reg <= MD_ARRAY;               // [R1]
              CMD_READ_STAT:  mode_reg <= MD_STAT;                // [R2]
              CMD_CLR_STAT:   stat_reg <= STAT_IDLE;              // [R2]
              CMD_LOCK_STAT:  mode_reg <= MD_LOCK;                // [R10]
              CMD_PROT_STAT:  mode_reg <= MD_PROT;                // [R12]
              CMD_PROGRAM: begin
                seq_reg  <= SQ_PDATA;                             // [R4]
                pcnt_reg <= 2'b00;
              end
              CMD_ERASE:      seq_reg  <= SQ_ERASE_CF;            // [R9]
              CMD_LOCK_PROG:  seq_reg  <= SQ_LOCK_CF;             // [R10]
              CMD_PROT_PROG:  seq_reg  <= SQ_PROT_CF;             // [R11]
              default: begin
                stat_reg[ST_PROG_ER]  <= 1'b1;                    // [R16]
                stat_reg[ST_ERASE_ER] <= 1'b1;                    // [R16]
              end
            endcase
          end
        end
        SQ_PDATA: begin
          if (wr) begin
            // First data word fixes the 8-byte aligned base
            // Address bits above the array width are not compared
            if (pcnt_reg == 2'b00)
              base_reg <= widx;
            if (!pd_ok || (pcnt_reg != 2'b00 && widx[AW-1:2] != base_reg[AW-1:2])) begin
              stat_reg[ST_PROG_ER] <= 1'b1;                       // [R16]
              seq_reg  <= SQ_IDLE;
              mode_reg <= MD_STAT;
            end else if (pcnt_reg == 2'(PROG_WORDS - 1)) begin
              pcnt_reg <= 2'b00;
              mode_reg <= MD_STAT;
              if (blk_bad) begin
                stat_reg[ST_PROG_ER] <= 1'b1;                     // [R15] [R16]
                seq_reg <= SQ_IDLE;
              end else begin
                stat_reg[ST_READY] <= 1'b0;                       // [R17]
                seq_reg <= SQ_RUN_PROG;                           // [R5]
              end
            end else
              pcnt_reg <= pcnt_reg + 2'b01;
          end
        end
        SQ_ERASE_CF: begin
          // A bad confirm must not touch the array, so the sweep is skipped
          if (wr) begin
            mode_reg <= MD_STAT;
            base_reg <= widx;
            ecnt_reg <= '0;
            if (!confirm || bus.addr[0] || blk_bad) begin
              stat_reg[ST_ERASE_ER] <= 1'b1;                      // [R16] [R15]
              seq_reg <= SQ_IDLE;
            end else begin
              stat_reg[ST_READY] <= 1'b0;                         // [R17]
              seq_reg <= SQ_RUN_ERASE;                            // [R9]
            end
          end
        end
        SQ_LOCK_CF: begin
          // Locking is refused while the array is protected
          if (wr) begin
            seq_reg  <= SQ_IDLE;
            mode_reg <= MD_STAT;
            if (confirm && !all_prot)
              lock_reg[blk] <= 1'b0;                              // [R10]
            else
              stat_reg[ST_PROG_ER] <= 1'b1;                       // [R16]
          end
        end
        SQ_PROT_CF: begin
          // Confirm address picks which of the two bits is cleared
          if (wr) begin
            seq_reg  <= SQ_IDLE;
            mode_reg <= MD_STAT;
            if (confirm && at_prot0)
              prot0_reg[blk] <= 1'b0;                             // [R11] [R14]
            else if (confirm && at_prot1)
              prot1_reg[blk] <= 1'b0;                             // [R11] [R14]
            else
              stat_reg[ST_PROG_ER] <= 1'b1;                       // [R16]
          end
        end
        SQ_RUN_PROG: begin
          // Writes during the run are acked and dropped
          pcnt_reg <= pcnt_reg + 2'b01;                           // [R17]
          if (pcnt_reg == 2'(PROG_WORDS - 1)) begin
            seq_reg <= SQ_IDLE;
            stat_reg[ST_READY] <= 1'b1;
          end
        end
        SQ_RUN_ERASE: begin
          ecnt_reg <= ecnt_reg + 1'b1;                            // [R17]
          if (&ecnt_reg) begin
            seq_reg <= SQ_IDLE;
            stat_reg[ST_READY] <= 1'b1;
          end
        end
        default: seq_reg <= SQ_IDLE;
      endcase
    end
  end

  // Answer comes straight from registers
  assign bus.ack   = ack_reg;
  assign bus.rdata = rdata_reg;
endmodule // fcs_device
`default_nettype wire

// file: rtl/fcs_host.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_host
  import fcs_pkg::*;
(
  input  wire logic        clk,              // System clock
  input  wire logic        arst_n,           // Async reset, active low
  fcs_if.host              bus,              // Path to the sequencer
  input  wire logic        op_valid,         // Operation request
  input  wire fcs_op_e     op,               // Operation code
  input  wire logic [31:0] op_addr,          // Target address
  input  wire logic [63:0] op_data,          // Program data, word 0 low
  input  wire logic        rewrite_mode_one, // CPU in rewrite mode one
  input  wire logic        running_from_ram, // Code runs from RAM
  output logic             op_ready,         // Idle, takes a request
  output logic             done,             // Operation finished pulse
  output logic             done_err,         // Refused, with done
  output logic [15:0]      rd_data           // Last read word
);
  fcs_op_e     op_reg;
  logic [31:0] addr_reg;
  logic [63:0] data_reg;
  logic [2:0]  step_reg;
  logic        act_reg;
  logic        req_reg;
  logic        we_reg;
  logic [31:0] baddr_reg;
  logic [15:0] bdata_reg;
  logic        done_reg;
  logic        err_reg;
  logic [15:0] rd_reg;

  // Words in each operation
  function automatic logic [2:0] op_len(input fcs_op_e o);
    case (o)
      OP_PROGRAM:                           op_len = 3'd5;     // [R4]
      OP_ERASE, OP_LOCK_PROG, OP_PROT_PROG: op_len = 3'd2;
      default:                              op_len = 3'd1;
    endcase
  endfunction

  // Command word of a one-step or first step
  function automatic logic [15:0] op_cmd(input fcs_op_e o);
    case (o)
      OP_MODE_ARRAY: op_cmd = CMD_READ_ARRAY;                  // [R1]
      OP_MODE_STAT:  op_cmd = CMD_READ_STAT;                   // [R2]
      OP_CLEAR:      op_cmd = CMD_CLR_STAT;                    // [R2]
      OP_PROGRAM:    op_cmd = CMD_PROGRAM;                     // [R4]
      OP_ERASE:      op_cmd = CMD_ERASE;                       // [R9]
      OP_LOCK_PROG:  op_cmd = CMD_LOCK_PROG;                   // [R10]
      OP_MODE_LOCK:  op_cmd = CMD_LOCK_STAT;                   // [R10]
      OP_PROT_PROG:  op_cmd = CMD_PROT_PROG;                   // [R11]
      OP_MODE_PROT:  op_cmd = CMD_PROT_STAT;                   // [R12]
      default:       op_cmd = CMD_READ_ARRAY;
    endcase
  endfunction

  // Refusals the host applies to itself
  wire refuse = (op == OP_MODE_STAT && rewrite_mode_one) ||      // [R3]
                ((op == OP_MODE_LOCK || op == OP_MODE_PROT) &&
                 !running_from_ram);                           // [R13]
  wire [1:0]  widx   = 2'(step_reg - 3'd1);
  wire [31:0] w_addr = (addr_reg & WORD_ALIGN) | {29'h0, widx, 1'b0}; // [R6] [R7] [R8]
  wire [15:0] w_data = data_reg[{widx, 4'h0} +: 16];           // [R8]
  wire        first  = step_reg == 3'd0;
  wire        conf   = op_reg == OP_PROGRAM ? 1'b0 : 1'b1;
  wire [31:0] nx_addr = op_reg == OP_READ ? addr_reg :
                        first ? CMD_ADDR : conf ? {addr_reg[31:1], 1'b0} : w_addr;
  wire [15:0] nx_data = first ? op_cmd(op_reg) : conf ? CMD_CONFIRM : w_data;
  wire        last   = step_reg == op_len(op_reg) - 3'd1;

  // Request issue and step walk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      baddr_reg <= 32'h00000000;
      bdata_reg <= 16'h0000;
      step_reg <= 3'd0;
      op_reg <= OP_READ;
      addr_reg <= 32'h00000000;
      data_reg <= 64'h0000000000000000;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      rd_reg <= 16'h0000;
    end else begin
      done_reg <= 1'b0;
      if (!act_reg && op_valid) begin
        if (refuse) begin
          done_reg <= 1'b1;
          err_reg  <= 1'b1;
        end else begin
          act_reg  <= 1'b1;
          err_reg  <= 1'b0;
          op_reg   <= op;
          addr_reg <= op_addr;
          data_reg <= op_data;
          step_reg <= 3'd0;
        end
      end else if (act_reg && !req_reg) begin
        req_reg   <= 1'b1;
        we_reg    <= op_reg != OP_READ;
        baddr_reg <= nx_addr;
        bdata_reg <= nx_data;
      end else if (req_reg && bus.ack) begin
        req_reg <= 1'b0;
        if (!we_reg)
          rd_reg <= bus.rdata;
        if (last) begin
          act_reg  <= 1'b0;
          done_reg <= 1'b1;
        end else
          step_reg <= step_reg + 3'd1;
      end
    end
  end

  assign bus.req   = req_reg;
  assign bus.we    = we_reg;
  assign bus.addr  = baddr_reg;
  assign bus.wdata = bdata_reg;
  assign op_ready  = !act_reg;
  assign done      = done_reg;
  assign done_err  = err_reg;
  assign rd_data   = rd_reg;
endmodule // fcs_host
`default_nettype wire

// file: test/fcs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_checker
  import fcs_pkg::*;
(
  input wire logic        clk,    // System clock
  input wire logic        arst_n, // Async reset, active low
  input wire logic        req,    // Access request
  input wire logic        we,     // Write when high
  input wire logic [31:0] addr,   // Byte address
  input wire logic [15:0] wdata,  // Write word
  input wire logic        ack,    // Device answer
  input wire logic [15:0] rdata   // Read word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Command writes and confirm writes seen on the bus
  wire cmd_wr  = req && we && (addr == CMD_ADDR);
  wire conf_wr = req && we && (wdata == CMD_CONFIRM) && (addr != CMD_ADDR);
  property p_ack_one;
    $rose(req) |=> ack ##1 (!ack && !req);
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a single pulse");
  property p_hold;
    req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(we);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved before ack");
  property p_rdata;
    $changed(rdata) |-> ack && !we;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read word changed outside a read");
  property p_even;
    req && we && (addr != CMD_ADDR) |-> !addr[0];
  endproperty
  a_even: assert property (p_even) else $error("data write to odd address");
  // A program set is the command then four words, three cycles apart
  property p_prog;
    $rose(req) && cmd_wr && (wdata == CMD_PROGRAM) |->
      ##3 (req && we && addr[2:0] == 3'h0)
      ##3 (req && we && addr[2:0] == 3'h2 && addr[31:3] == $past(addr[31:3], 3))
      ##3 (req && we && addr[2:0] == 3'h4 && addr[31:3] == $past(addr[31:3], 3))
      ##3 (req && we && addr[2:0] == 3'h6 && addr[31:3] == $past(addr[31:3], 3));
  endproperty
  a_prog: assert property (p_prog) else $error("program set malformed");
  property p_erase;
    $rose(req) && cmd_wr && (wdata == CMD_ERASE) |-> ##3 (conf_wr && !addr[0]);
  endproperty
  a_erase: assert property (p_erase) else $error("erase without confirm");
  property p_lock;
    $rose(req) && cmd_wr && (wdata == CMD_LOCK_PROG) |-> ##3 conf_wr;
  endproperty
  a_lock: assert property (p_lock) else $error("lock program without confirm");
  property p_prot;
    $rose(req) && cmd_wr && (wdata == CMD_PROT_PROG) |->
      ##3 (conf_wr && (addr[14:0] == PROT0_OFS || addr[14:0] == PROT1_OFS));
  endproperty
  a_prot: assert property (p_prot) else $error("protect confirm misplaced");
endmodule // fcs_checker
`default_nettype wire

// file: test/flash_command_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_tb
  import fcs_pkg::*;
;
  logic        clk;              // Bench clock
  logic        arst_n;           // Async reset
  logic        op_valid;         // Operation request
  fcs_op_e     op;               // Operation code
  logic [31:0] op_addr;          // Target address
  logic [63:0] op_data;          // Program data
  logic        rewrite_mode_one; // CPU in rewrite mode one
  logic        running_from_ram; // Code runs from RAM
  logic        op_ready;         // Host idle
  logic        done;             // Finished pulse
  logic        done_err;         // Refusal flag
  logic [15:0] rd_data;          // Last read word
  int          fail_count;       // Mismatches
  int          cmp_count;        // Comparisons
  int          seed;             // Random seed
  logic [31:0] base;             // Program base
  logic [63:0] pd;               // Program data
  logic [15:0] mem [int];        // Array model, byte address keyed
  fcs_if bif ();
  fcs_device #(.AW(10), .BW(7)) fcs_device_inst (.clk(clk), .arst_n(arst_n), .bus(bif.dev));
  fcs_host fcs_host_inst (
    .clk(clk), .arst_n(arst_n), .bus(bif.host), .op_valid(op_valid), .op(op),
    .op_addr(op_addr), .op_data(op_data), .rewrite_mode_one(rewrite_mode_one),
    .running_from_ram(running_from_ram), .op_ready(op_ready), .done(done),
    .done_err(done_err), .rd_data(rd_data));
  fcs_checker fcs_checker_inst (
    .clk(clk), .arst_n(arst_n), .req(bif.req), .we(bif.we), .addr(bif.addr),
    .wdata(bif.wdata), .ack(bif.ack), .rdata(bif.rdata));
  // Free-running 125 MHz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Inputs move on falling edges so the host samples them settled
  task automatic run_op(input fcs_op_e o, input logic [31:0] a, input logic [63:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (op_ready !== 1'b1) @(negedge clk);
    op = o;
    op_addr = a;
    op_data = d;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) chk(16'h0000, 16'h0001);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [15:0] e, input logic [15:0] m);
    run_op(OP_READ, a, 64'h0);
    chk(rd_data & m, e & m);
  endtask
  // Long device runs are simply waited out
  task automatic settle();
    repeat (200) @(negedge clk);
  endtask
  initial begin
    fail_count = 0;
    cmp_count = 0;
    seed = 32'h5BC7;
    arst_n = 1'b0;
    op_valid = 1'b0;
    op = OP_READ;
    op_addr = 32'h0;
    op_data = 64'h0;
    rewrite_mode_one = 1'b0;
    running_from_ram = 1'b1;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    // Erase, then a read during the run shows busy
    run_op(OP_ERASE, 32'h500, 64'h0);
    rdc(32'h500, 16'h0000, 16'h0080);
    // A program set sent while the erase runs must be dropped
    run_op(OP_PROGRAM, 32'h520, {$random(seed), $random(seed)});
    settle();
    for (int k = 0; k < 3; k++) begin
      base = 32'h500 + 32'(k * 8);
      pd = {$random(seed), $random(seed)};
      run_op(OP_PROGRAM, base, pd);
      for (int i = 0; i < 4; i++) mem[base + 2 * i] = pd[16 * i +: 16];
      repeat (10) @(negedge clk);
      run_op(OP_MODE_ARRAY, CMD_ADDR, 64'h0);
      for (int i = 0; i < 4; i++) rdc(base + 32'(2 * i), mem[base + 2 * i], 16'hFFFF);
    end
    rdc(32'h5F0, ERASED_WORD, 16'hFFFF);
    rdc(32'h520, ERASED_WORD, 16'hFFFF);
    // Host-side refusals
    rewrite_mode_one = 1'b1;
    run_op(OP_MODE_STAT, CMD_ADDR, 64'h0);
    chk({15'h0, done_err}, 16'h0001);
    rewrite_mode_one = 1'b0;
    run_op(OP_MODE_STAT, CMD_ADDR, 64'h0);
    chk({15'h0, done_err}, 16'h0000);
    rdc(32'h500, 16'h0080, 16'h00FF);
    running_from_ram = 1'b0;
    run_op(OP_MODE_LOCK, CMD_ADDR, 64'h0);
    chk({15'h0, done_err}, 16'h0001);
    run_op(OP_MODE_PROT, CMD_ADDR, 64'h0);
    chk({15'h0, done_err}, 16'h0001);
    running_from_ram = 1'b1;
    // Lock block two, then programming it must fail
    run_op(OP_LOCK_PROG, 32'h200, 64'h0);
    settle();
    run_op(OP_MODE_LOCK, CMD_ADDR, 64'h0);
    rdc(32'h200, 16'h0000, 16'h0001);
    rdc(32'h400, 16'h0001, 16'h0001);
    run_op(OP_PROGRAM, 32'h200, pd);
    settle();
    run_op(OP_MODE_STAT, CMD_ADDR, 64'h0);
    rdc(32'h500, 16'h0010, 16'h0010);
    run_op(OP_CLEAR, CMD_ADDR, 64'h0);
    run_op(OP_MODE_STAT, CMD_ADDR, 64'h0);
    rdc(32'h500, 16'h0080, 16'h00FF);
    // One protect bit at zero shuts the whole array
    run_op(OP_PROT_PROG, 32'h300, 64'h0);
    settle();
    run_op(OP_MODE_PROT, CMD_ADDR, 64'h0);
    rdc(32'h300, 16'h0000, 16'h0001);
    rdc(32'h100, 16'h0001, 16'h0001);
    run_op(OP_PROGRAM, 32'h5F0, {$random(seed), $random(seed)});
    settle();
    run_op(OP_MODE_STAT, CMD_ADDR, 64'h0);
    rdc(32'h500, 16'h0010, 16'h0010);
    run_op(OP_MODE_ARRAY, CMD_ADDR, 64'h0);
    rdc(32'h5F0, ERASED_WORD, 16'hFFFF);
    rdc(32'h500, mem[32'h500], 16'hFFFF);
    finish_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 20000);
    fail_count++;
    finish_test();
  end
endmodule // flash_command_sequencer_tb
`default_nettype wire
